// ---- common/trsd_pkg.sv ----
// Package for the tape reader serial transmitter: constants, types, register map
package trsd_pkg;
  // Register byte offsets
  localparam logic [11:0] TRSD_CTRL_OFS = 12'h000;
  localparam logic [11:0] TRSD_STAT_OFS = 12'h004;
  localparam logic [11:0] TRSD_DIV_OFS = 12'h008;
  localparam logic [11:0] TRSD_TAPE_OFS = 12'h00c;
  localparam logic [11:0] TRSD_READ_OFS = 12'h010;
  // Control fields
  localparam int TRSD_CTRL_MODE_LSB = 0;
  localparam int TRSD_CTRL_PAR_BIT = 2;
  localparam int TRSD_CTRL_RDST_BIT = 3;
  // Status fields
  localparam int TRSD_STAT_TRIG_BIT = 0;
  localparam int TRSD_STAT_SENSE_BIT = 1;
  localparam int TRSD_STAT_DIST_BIT = 2;
  localparam int TRSD_STAT_TRDY_BIT = 3;
  localparam int TRSD_STAT_TOUT_BIT = 4;
  localparam int TRSD_STAT_TIGHT_BIT = 5;
  localparam int TRSD_STAT_FREE_BIT = 6;
  localparam int TRSD_STAT_LINE_BIT = 7;
  // Reset values
  localparam logic [15:0] TRSD_DIV_RST = 16'h0a2b;
  localparam logic [1:0] TRSD_MODE_RST = 2'h1;
  // Frame shape: start, eight data, two stop units
  localparam int TRSD_DATA_BITS = 8;
  localparam int TRSD_STOP_UNITS = 2;
  localparam int TRSD_FRAME_UNITS = 1 + TRSD_DATA_BITS + TRSD_STOP_UNITS;
  localparam logic [3:0] TRSD_FRAME_LAST = 4'(TRSD_FRAME_UNITS - 1);
  localparam logic [3:0] TRSD_STOP_FIRST = 4'(1 + TRSD_DATA_BITS);
  // Sensing cycle: 360 degrees, one step per unit interval tick
  localparam int TRSD_DEG_FULL = 360;
  localparam int TRSD_DEG_REARM = 43;
  localparam int TRSD_DEG_LAUNCH = 133;
  localparam int TRSD_DEG_FEED = 250;
  localparam int TRSD_DEG_STEP = 10;
  localparam logic [5:0] TRSD_PH_LAST = 6'(TRSD_DEG_FULL / TRSD_DEG_STEP - 1);
  localparam logic [5:0] TRSD_PH_REARM = 6'(TRSD_DEG_REARM / TRSD_DEG_STEP);
  localparam logic [5:0] TRSD_PH_LAUNCH = 6'(TRSD_DEG_LAUNCH / TRSD_DEG_STEP);
  localparam logic [5:0] TRSD_PH_FEED = 6'(TRSD_DEG_FEED / TRSD_DEG_STEP);
  localparam logic [5:0] TRSD_PH_CAPTURE = 6'h01;
  localparam logic [5:0] TRSD_PH_TRANSFER = 6'h02;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;

  typedef enum logic [1:0] {TRSD_MODE_STOP = 2'h1, TRSD_MODE_RUN = 2'h0,
    TRSD_MODE_FREE = 2'h2} trsd_mode_t;
  typedef enum {TRSD_DS_IDLE, TRSD_DS_SEND} trsd_dstate_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } trsd_req_t;
endpackage : trsd_pkg

// ---- rtl/trsd_top.sv ----
// Tape reader serial transmitter: sensing cycle, serialiser, APB registers
// Functional notes
// - Data bits carry the ASCII character code
// - Frame is start space, eight data, stop mark
// - One frame lasts eleven unit intervals
// - Even parity sets eighth bit for even marks
// - Sense store holds last character for serialiser
// - Optional read store drives parallel outputs
// - Capture holes first, then transfer to stores
// - Entering run with tape starts sensing
// - Trigger is AND of run, not tight, not tape-out
// - Sensing cycle rearms; repeats only if triggered
// - Each sensing cycle launches one distributor cycle
// - Only sensing progress starts the distributor
// - Distributor sends elements in turn, rearms early
// - Line element is sense bit gated by slot
// - Eleven line positions: start, eight code, two stop
// - Each sensing cycle feeds tape one position
// - Tape out or tight tape stops sensing
// - Stop mode halts sensing and feeding
// - Free mode also disengages the feed drive
// - Trigger rearms near 43 degrees
// - Launch contact acts near 133 degrees
// - Tape feed step near 250 degrees
// - Cycles repeat back to back while triggered
//
// Decided for this implementation: the APB register port and the register addresses.
module trsd_top
  import trsd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] TAPE_HOLES,
  input wire logic TAPE_PRESENT,
  input wire logic TAPE_TIGHT,
  output logic TAPE_FEED,
  output logic FEED_ENGAGED,
  output logic LINE_OUT,
  output logic [7:0] READ_OUT,
  output logic READ_STROBE
);
  trsd_req_t req;
  logic acc;
  logic wr_en;
  logic [1:0] mode_reg;
  logic parity_reg;
  logic rdst_reg;
  logic [15:0] div_reg;
  logic [15:0] div_cnt_reg;
  logic unit_tick;
  logic addr_mapped;

  logic [1:0] mode_prev_reg;
  logic trigger;
  logic run_sel;
  logic tape_ok;
  logic armed_reg;
  logic sense_busy_reg;
  logic [5:0] phase_reg;
  logic [7:0] capture_reg;
  logic [7:0] sense_reg;
  logic [7:0] read_reg;
  logic launch_reg;

  trsd_dstate_t dstate_reg;
  logic [3:0] slot_reg;
  logic [TRSD_FRAME_UNITS-1:0] slot_onehot;
  logic [TRSD_FRAME_UNITS-1:0] frame_bits;
  logic [7:0] data_bits;
  logic parity_bit;
  logic line_next;
  logic [31:0] rdata_next;

  assign req = '{addr: PADDR, write: PWRITE, wdata: PWDATA};
  assign acc = PSEL && PENABLE;
  assign wr_en = acc && req.write;
  assign addr_mapped = (req.addr == TRSD_CTRL_OFS) || (req.addr == TRSD_STAT_OFS)
    || (req.addr == TRSD_DIV_OFS) || (req.addr == TRSD_TAPE_OFS)
    || (req.addr == TRSD_READ_OFS);

  // Zero-wait APB slave; writes land at the access edge
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      mode_reg <= TRSD_MODE_RST;
      parity_reg <= 1'b0;
      rdst_reg <= 1'b1;
      div_reg <= TRSD_DIV_RST;
    end
    else if (wr_en && req.addr == TRSD_CTRL_OFS)
    begin
      mode_reg <= req.wdata[TRSD_CTRL_MODE_LSB +: 2];
      parity_reg <= req.wdata[TRSD_CTRL_PAR_BIT];
      rdst_reg <= req.wdata[TRSD_CTRL_RDST_BIT];
    end
    else if (wr_en && req.addr == TRSD_DIV_OFS)
    begin
      // New divisor applies at once; the count is compared, not reloaded
      div_reg <= req.wdata[15:0];
    end
  end

  always_comb
  begin
    rdata_next = 32'h0;
    case (req.addr)
      TRSD_CTRL_OFS:
      begin
        rdata_next[TRSD_CTRL_MODE_LSB +: 2] = mode_reg;
        rdata_next[TRSD_CTRL_PAR_BIT] = parity_reg;
        rdata_next[TRSD_CTRL_RDST_BIT] = rdst_reg;
      end
      TRSD_STAT_OFS:
      begin
        rdata_next[TRSD_STAT_TRIG_BIT] = trigger;
        rdata_next[TRSD_STAT_SENSE_BIT] = sense_busy_reg;
        rdata_next[TRSD_STAT_DIST_BIT] = (dstate_reg == TRSD_DS_SEND);
        rdata_next[TRSD_STAT_TRDY_BIT] = armed_reg;
        rdata_next[TRSD_STAT_TOUT_BIT] = !TAPE_PRESENT;
        rdata_next[TRSD_STAT_TIGHT_BIT] = TAPE_TIGHT;
        rdata_next[TRSD_STAT_FREE_BIT] = (mode_reg == TRSD_MODE_FREE);
        rdata_next[TRSD_STAT_LINE_BIT] = LINE_OUT;
      end
      TRSD_DIV_OFS: rdata_next[15:0] = div_reg;
      TRSD_TAPE_OFS: rdata_next[7:0] = sense_reg;
      TRSD_READ_OFS: rdata_next[7:0] = read_reg;
      default: rdata_next = 32'h0;
    endcase
  end

  // Read data is registered in setup so it stands at the access edge
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !addr_mapped;
      // Zero outside read answers, so stale data never looks valid
      PRDATA <= (PSEL && !PENABLE && !req.write) ? rdata_next : 32'h0;
    end
  end

  // Unit interval divider stands in for the constant-speed drive
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      div_cnt_reg <= 16'h0;
    end
    else if (unit_tick)
    begin
      div_cnt_reg <= 16'h0;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 16'h1;
    end
  end
  // Greater-or-equal, so a smaller new divisor never strands the count
  assign unit_tick = (div_cnt_reg >= div_reg);

  // Permissive chain in series, as the magnet circuit
  // Any mode code but run opens the chain, so code 3 acts as stop
  assign run_sel = (mode_reg == TRSD_MODE_RUN);
  assign tape_ok = TAPE_PRESENT && !TAPE_TIGHT;
  assign trigger = run_sel && tape_ok;

  // Sensing cycle: one phase step per unit tick
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      sense_busy_reg <= 1'b0;
      phase_reg <= 6'h0;
      armed_reg <= 1'b1;
      mode_prev_reg <= TRSD_MODE_RST;
      TAPE_FEED <= 1'b0;
      launch_reg <= 1'b0;
    end
    else
    begin
      mode_prev_reg <= mode_reg;
      TAPE_FEED <= 1'b0;
      // Rearm on entry to run, so a reader stopped mid-cycle restarts
      if (mode_reg == TRSD_MODE_RUN && mode_prev_reg != TRSD_MODE_RUN)
      begin
        armed_reg <= 1'b1;
      end
      if (unit_tick)
      begin
        // Contact stands one unit, so the distributor starts on a tick
        launch_reg <= 1'b0;
        if (!sense_busy_reg)
        begin
          if (trigger && armed_reg)
          begin
            sense_busy_reg <= 1'b1;
            phase_reg <= 6'h0;
            armed_reg <= 1'b0;
          end
        end
        else
        begin
          phase_reg <= phase_reg + 6'h1;
          if (phase_reg == TRSD_PH_REARM)
          begin
            armed_reg <= 1'b1;
          end
          if (phase_reg == TRSD_PH_LAUNCH)
          begin
            launch_reg <= 1'b1;
          end
          // Feed drive disengaged in free mode, so no step reaches the tape
          if (phase_reg == TRSD_PH_FEED && mode_reg != TRSD_MODE_FREE)
          begin
            TAPE_FEED <= 1'b1;
          end
          if (phase_reg == TRSD_PH_LAST)
          begin
            sense_busy_reg <= 1'b0;
          end
        end
      end
    end
  end

  // Feed pawl follows the mode lever, not the cycle
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      FEED_ENGAGED <= 1'b1;
    end
    else
    begin
      FEED_ENGAGED <= (mode_reg != TRSD_MODE_FREE);
    end
  end

  // Capture first, then transfer into both stores
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      capture_reg <= 8'h0;
      sense_reg <= 8'h0;
      read_reg <= 8'h0;
      READ_OUT <= 8'h0;
      READ_STROBE <= 1'b0;
    end
    else
    begin
      READ_STROBE <= 1'b0;
      READ_OUT <= rdst_reg ? read_reg : 8'h0;
      if (unit_tick && sense_busy_reg && phase_reg == TRSD_PH_CAPTURE)
      begin
        capture_reg <= TAPE_HOLES;
      end
      if (unit_tick && sense_busy_reg && phase_reg == TRSD_PH_TRANSFER)
      begin
        sense_reg <= capture_reg;
        read_reg <= capture_reg;
        READ_STROBE <= rdst_reg;
        // Outputs change with the strobe, not one clock after it
        READ_OUT <= rdst_reg ? capture_reg : 8'h0;
      end
    end
  end

  // Even parity replaces code bit eight when selected
  // Parity is read live, so software changes it only between frames
  assign parity_bit = parity_reg ? ^sense_reg[TRSD_DATA_BITS-2:0]
    : sense_reg[TRSD_DATA_BITS-1];
  assign data_bits = {parity_bit, sense_reg[TRSD_DATA_BITS-2:0]};
  assign frame_bits = {{TRSD_STOP_UNITS{LINE_MARK}}, data_bits, LINE_SPACE};

  // Each slot gates its stored bit onto the line
  genvar g;
  generate
    for (g = 0; g < TRSD_FRAME_UNITS; g++)
    begin : g_slot
      assign slot_onehot[g] = (slot_reg == 4'(g));
    end
  endgenerate
  assign line_next = (dstate_reg == TRSD_DS_SEND) ? |(slot_onehot & frame_bits)
    : LINE_MARK;

  // Distributor: launched only by the sensing cycle contact
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      dstate_reg <= TRSD_DS_IDLE;
      slot_reg <= 4'h0;
      LINE_OUT <= LINE_MARK;
    end
    else
    begin
      LINE_OUT <= line_next;
      case (dstate_reg)
        TRSD_DS_IDLE:
        begin
          // Starting on a tick gives the start element a whole unit
          if (launch_reg && unit_tick)
          begin
            dstate_reg <= TRSD_DS_SEND;
            slot_reg <= 4'h0;
          end
        end
        TRSD_DS_SEND:
        begin
          if (unit_tick)
          begin
            // After the second stop unit the idle branch keeps the line marking
            if (slot_reg == TRSD_FRAME_LAST)
            begin
              dstate_reg <= TRSD_DS_IDLE;
            end
            else
            begin
              slot_reg <= slot_reg + 4'h1;
            end
          end
        end
        default: dstate_reg <= TRSD_DS_IDLE;
      endcase
    end
  end
endmodule // trsd_top

// ---- test/tb_top.sv ----
// Self-checking bench for the tape reader serial transmitter
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module tb_top
  import trsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 4;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, present = 0, tight = 0, par = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, feed, engaged, line, strobe, rx_ok, er;
  logic [7:0] holes = 8'h2d, lf = 8'h2d, rx_byte, rdout, e8, last_h;
  logic [7:0] exp_q[$];
  int num_errors = 0, compares = 0, rx_cnt = 0, feeds = 0, f0;
  trsd_top dut (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TAPE_HOLES(holes), .TAPE_PRESENT(present), .TAPE_TIGHT(tight), .TAPE_FEED(feed),
    .FEED_ENGAGED(engaged), .LINE_OUT(line), .READ_OUT(rdout), .READ_STROBE(strobe));
  trsd_rx_model rx (.clk(clk), .line(line), .div(16'(UNIT - 1)), .rx_byte(rx_byte),
    .rx_ok(rx_ok));
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expectation noted when a character is sensed, new holes after feed
  always @(posedge clk)
  begin
    if (strobe === 1'b1)
    begin
      exp_q.push_back(par ? {^holes[6:0], holes[6:0]} : holes);
      last_h = holes;
    end
    if (feed === 1'b1)
    begin
      lf = nx(lf);
      holes <= lf;
      feeds++;
    end
  end
  always @(posedge clk)
    if (rx_ok === 1'b1)
    begin
      rx_cnt++;
      e8 = exp_q.pop_front();
      `CHK(rx_byte, e8)
    end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_rx(input int n);
    repeat (20000)
    begin
      if (rx_cnt >= n)
        break;
      @(posedge clk);
    end
    `CHK(rx_cnt >= n, 1'b1)
  endtask
  task automatic print_verdict();
    $display("counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(0, TRSD_CTRL_OFS, 0);
    `CHK(rd, 32'h00000009)
    apb(0, TRSD_DIV_OFS, 0);
    `CHK(rd[15:0], TRSD_DIV_RST)
    apb(0, 12'h020, 0);
    `CHK({er, rd}, 33'h100000000)
    apb(0, TRSD_STAT_OFS, 0);
    `CHK(rd, 32'h00000098)
    `CHK({line, engaged}, 2'b11)
    $display("test reset done");
    apb(1, TRSD_DIV_OFS, UNIT - 1);
    present <= 1'b1;
    apb(1, TRSD_CTRL_OFS, 32'h00000008);
    wait_rx(4);
    apb(1, TRSD_CTRL_OFS, 32'h00000009);
    // Let the cycle in progress finish before parity changes
    repeat (40 * UNIT) @(posedge clk);
    par = 1'b1;
    apb(1, TRSD_CTRL_OFS, 32'h0000000c);
    wait_rx(rx_cnt + 4);
    $display("test run and parity done");
    for (int i = 0; i < 4; i++)
    begin
      tight <= i == 0;
      present <= i != 1;
      apb(1, TRSD_CTRL_OFS, i == 2 ? 32'h0000000d : i == 3 ? 32'h0000000e : 32'h0000000c);
      repeat (40 * UNIT) @(posedge clk);
      f0 = feeds;
      repeat (80 * UNIT) @(posedge clk);
      `CHK(feeds, f0)
      `CHK(engaged, i != 3)
      tight <= 1'b0;
      present <= 1'b1;
      apb(1, TRSD_CTRL_OFS, 32'h0000000c);
      wait_rx(rx_cnt + 2);
      $display("test block %0d done", i);
    end
    apb(1, TRSD_CTRL_OFS, 32'h0000000d);
    repeat (40 * UNIT) @(posedge clk);
    apb(0, TRSD_TAPE_OFS, 0);
    `CHK(rd[7:0], last_h)
    `CHK(rdout, last_h)
    apb(1, TRSD_CTRL_OFS, 32'h00000005);
    apb(0, TRSD_READ_OFS, 0);
    `CHK(rd[7:0], last_h)
    `CHK(rdout, 8'h00)
    $display("test stores done");
    print_verdict();
  end
endmodule // tb_top

// ---- test/trsd_monitor.sv ----
// Port checker for the tape reader serial transmitter
module trsd_monitor
  import trsd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [7:0] TAPE_HOLES,
  input wire logic TAPE_PRESENT,
  input wire logic TAPE_TIGHT,
  input wire logic TAPE_FEED,
  input wire logic FEED_ENGAGED,
  input wire logic LINE_OUT,
  input wire logic [7:0] READ_OUT,
  input wire logic READ_STROBE
);
  logic [15:0] div_reg;
  logic run_reg;
  int fall_reg;
  int low_reg;
  int blk_reg;
  int gap_reg;
  int unit;
  assign unit = div_reg + 1;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // Unit length and mode follow bus writes
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      div_reg <= TRSD_DIV_RST;
      run_reg <= 1'b0;
    end
    else if (PSEL && PENABLE && PWRITE && PADDR == TRSD_DIV_OFS)
      div_reg <= PWDATA[15:0];
    else if (PSEL && PENABLE && PWRITE && PADDR == TRSD_CTRL_OFS)
      run_reg <= PWDATA[1:0] == TRSD_MODE_RUN;
  end
  always_ff @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      fall_reg <= 1 << 24;
      low_reg <= 0;
      blk_reg <= 0;
      gap_reg <= 1 << 24;
    end
    else
    begin
      // Counts from the start element only; falls inside a frame are data
      fall_reg <= ($fell(LINE_OUT) && fall_reg >= 9 * unit) ? 0 : fall_reg + 1;
      low_reg <= LINE_OUT ? 0 : low_reg + 1;
      blk_reg <= (run_reg && TAPE_PRESENT && !TAPE_TIGHT) ? 0 : blk_reg + 1;
      gap_reg <= TAPE_FEED ? 0 : gap_reg + 1;
    end
  end
  a_reset_idle: assert property (disable iff (1'b0) !RSTN |=>
    LINE_OUT && FEED_ENGAGED && !TAPE_FEED && READ_OUT == 8'h00) else $error("reset state");
  a_frame_gap: assert property ($fell(LINE_OUT) && fall_reg >= 9 * unit |->
    fall_reg >= 11 * unit) else $error("frame too short");
  a_mark_outside: assert property (!LINE_OUT && !$fell(LINE_OUT) |->
    fall_reg < 9 * unit) else $error("space outside frame");
  a_whole_units: assert property ($rose(LINE_OUT) |-> low_reg % unit == 0)
    else $error("element not whole units");
  a_blocked_feed: assert property (TAPE_FEED |-> blk_reg < 27 * unit)
    else $error("feed while blocked");
  a_feed_spacing: assert property (TAPE_FEED |-> gap_reg >= 35 * unit)
    else $error("feeds too close");
  a_free_feed: assert property (!FEED_ENGAGED |-> !TAPE_FEED)
    else $error("feed while free");
  a_read_store: assert property (READ_STROBE |-> READ_OUT == TAPE_HOLES)
    else $error("read store wrong");
endmodule // trsd_monitor
bind trsd_top trsd_monitor mon (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .TAPE_HOLES(TAPE_HOLES),
  .TAPE_PRESENT(TAPE_PRESENT), .TAPE_TIGHT(TAPE_TIGHT), .TAPE_FEED(TAPE_FEED),
  .FEED_ENGAGED(FEED_ENGAGED), .LINE_OUT(LINE_OUT), .READ_OUT(READ_OUT),
  .READ_STROBE(READ_STROBE));

// ---- test/trsd_rx_model.sv ----
// Receiving station model: decodes one start-stop frame at a time
module trsd_rx_model (
  input wire logic clk,
  input wire logic line,
  input wire logic [15:0] div,
  output logic [7:0] rx_byte,
  output logic rx_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  int u;
  logic bad;
  initial
  begin
    rx_ok = 1'b0;
    rx_byte = 8'h00;
    forever
    begin
      @(negedge line);
      u = div + 1;
      // Mid-unit sampling tolerates edge placement
      repeat (u / 2 + 1) @(posedge clk);
      bad = line;
      for (int i = 0; i < 8; i++)
      begin
        repeat (u) @(posedge clk);
        rx_byte[i] <= line;
      end
      for (int i = 0; i < 2; i++)
      begin
        repeat (u) @(posedge clk);
        bad = bad | !line;
      end
      rx_ok <= !bad;
      @(posedge clk);
      rx_ok <= 1'b0;
    end
  end
endmodule // trsd_rx_model
